// ### shared/ast_pkg.sv
// Constants, types and register map of the async serial port.
// Assumes an APB slave wrapper with 32-bit data and word indices.
package ast_pkg;

  // ---------------------------------------------------------------
  // Register word indices; byte address is four times the index.
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_FLAGS   = 8'h0c; // Peripheral flags.
  localparam logic [7:0] IDX_RX_STAT = 8'h18; // Receive status.
  localparam logic [7:0] IDX_TX_BUF  = 8'h19; // Transmit buffer.
  localparam logic [7:0] IDX_RX_BUF  = 8'h1a; // Receive buffer.
  localparam logic [7:0] IDX_ENABLES = 8'h8c; // Peripheral enables.
  localparam logic [7:0] IDX_TX_STAT = 8'h98; // Transmit status.
  localparam logic [7:0] IDX_BAUD    = 8'h99; // Baud divisor.

  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int FL_RX_READY = 5; // Receive ready flag.
  localparam int FL_TX_EMPTY = 4; // Transmit buffer empty flag.
  localparam int RS_PORT_EN  = 7; // Port enable.
  localparam int RS_RX9      = 6; // Nine-bit receive select.
  localparam int RS_CONTINUOUS_RX_ENABLE     = 4; // Continuous receive enable.
  localparam int RS_ADDRESS_DETECT_ENABLE     = 3; // Address detect enable.
  localparam int RS_FRAMING_ERROR     = 2; // Framing error.
  localparam int RS_OVERRUN_ERROR     = 1; // Overrun error.
  localparam int RS_RX_NINTH_BIT     = 0; // Received ninth bit.
  localparam int TS_CSRC     = 7; // Clock source, stored only.
  localparam int TS_TX9      = 6; // Nine-bit transmit select.
  localparam int TS_TRANSMIT_ENABLE     = 5; // Transmit enable.
  localparam int TS_SYNC     = 4; // Synchronous select.
  localparam int TS_HIGH_SPEED_SELECT     = 2; // High-speed select.
  localparam int TS_SHIFT_REG_EMPTY     = 1; // Shift register empty.
  localparam int TS_TX_NINTH_BIT     = 0; // Ninth transmit bit.

  // ---------------------------------------------------------------
  // Reset values and timing counts.
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE    = 8'h00; // Plain reset byte.
  localparam logic [7:0] RST_TX_STAT = 8'h02; // Shift-empty set.
  localparam logic [7:0] TS_RW_MASK  = 8'hfd; // Writable bits.
  localparam logic [7:0] RS_RW_MASK  = 8'hd8; // Writable bits.
  localparam logic [1:0] PRE_LAST    = 2'h3;  // x64 down to x16.
  localparam logic [3:0] PHASE_LAST  = 4'hf;  // Sixteen per bit.
  localparam logic [3:0] SAMPLE_A    = 4'h6;  // Seventh sample.
  localparam logic [3:0] SAMPLE_B    = 4'h7;  // Eighth sample.
  localparam logic [3:0] SAMPLE_C    = 4'h8;  // Ninth sample.
  localparam logic [3:0] TX_STEPS_8  = 4'hb;  // Ten bits plus end.
  localparam logic [3:0] TX_STEPS_9  = 4'hc;  // Eleven bits plus end.
  localparam logic [3:0] RX_LAST_8   = 4'h7;  // Last data index.
  localparam logic [3:0] RX_LAST_9   = 4'h8;  // Last data index.

  // ---------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------
  // One queued receive word with its status.
  typedef struct packed {
    logic       framing_error;
    logic       ninth;
    logic [7:0] data;
  } ast_rx_word_t;

  // Receiver progress through a frame.
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } ast_rx_state_t;

endpackage

// ### logic/ast_serial_port.sv
// Async serial transmitter and receiver with an APB register slave.
// Assumes a single pclk domain; the receive pin is synchronous.
`timescale 1ns/1ps
module ast_serial_port
#(
  parameter int ADDR_W   = 12,
  parameter int RX_DEPTH = 2
)
(
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Power state.
  input  wire logic              sleep_mode,
  // Serial pins.
  input  wire logic              receive_pin,
  output logic                   transmit_pin_out,
  output logic                   transmit_pin_oe
);

  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam logic [PTR_W:0] FIFO_FULL = (PTR_W+1)'(RX_DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(RX_DEPTH - 1);

  // ---------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------
  logic [7:0] rx_ctl;          // Writable receive status bits.
  logic [7:0] tx_ctl;          // Writable transmit status bits.
  logic [7:0] transmit_buffer; // Pending transmit byte.
  logic [7:0] enables;         // Peripheral enable register.
  logic [7:0] baud_divisor;    // Rate generator reload.
  logic       tx_buf_full;     // Transmit buffer holds a byte.
  logic       tx_empty_flag;   // Transmit buffer empty flag.
  logic       overrun_error;   // Receive overrun.

  // ---------------------------------------------------------------
  // APB decode.
  // ---------------------------------------------------------------
  wire        acc    = psel & penable;
  wire        done   = acc & pready;
  wire        wr     = done & pwrite;
  wire        rd     = done & ~pwrite;
  wire [7:0]  idx    = paddr[9:2];
  wire        hi_ok  = (paddr >> 10) == '0;
  wire        al_ok  = paddr[1:0] == 2'b00;
  wire        s_fl   = idx == ast_pkg::IDX_FLAGS;
  wire        s_rs   = idx == ast_pkg::IDX_RX_STAT;
  wire        s_tb   = idx == ast_pkg::IDX_TX_BUF;
  wire        s_rb   = idx == ast_pkg::IDX_RX_BUF;
  wire        s_en   = idx == ast_pkg::IDX_ENABLES;
  wire        s_ts   = idx == ast_pkg::IDX_TX_STAT;
  wire        s_bd   = idx == ast_pkg::IDX_BAUD;
  wire        hit    = hi_ok & al_ok &
                       (s_fl | s_rs | s_tb | s_rb | s_en | s_ts | s_bd);
  wire        wr_ts  = wr & hit & s_ts;
  wire        wr_rs  = wr & hit & s_rs;
  wire        wr_tb  = wr & hit & s_tb;
  wire        pop    = rd & hit & s_rb;
  wire [7:0]  wbyte  = pwdata[7:0];

  // ---------------------------------------------------------------
  // Mode decode.
  // ---------------------------------------------------------------
  // Async operation needs the port on and sync select clear.
  // async mode gate
  wire async_on = rx_ctl[ast_pkg::RS_PORT_EN] &
                  ~tx_ctl[ast_pkg::TS_SYNC];
  wire tx_on    = async_on & tx_ctl[ast_pkg::TS_TRANSMIT_ENABLE];
  wire rx_on    = async_on & rx_ctl[ast_pkg::RS_CONTINUOUS_RX_ENABLE];
  wire hs       = tx_ctl[ast_pkg::TS_HIGH_SPEED_SELECT];
  wire rx9      = rx_ctl[ast_pkg::RS_RX9];
  wire transmit_enable_set = wr_ts & wbyte[ast_pkg::TS_TRANSMIT_ENABLE] &
                  ~tx_ctl[ast_pkg::TS_TRANSMIT_ENABLE];

  // ---------------------------------------------------------------
  // Rate generator and sample tick.
  // ---------------------------------------------------------------
  logic [7:0] brg_cnt; // Down counter of the rate generator.
  logic [1:0] pre_cnt; // Divides x64 output to x16 samples.
  wire brg_run  = async_on & ~sleep_mode & (tx_on | rx_on);
  wire brg_tick = brg_run & (brg_cnt == '0);
  wire s_tick   = brg_tick & (hs | (pre_cnt == ast_pkg::PRE_LAST));

  // One shared counter serves both directions.
  // shared rate generator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brg_cnt <= ast_pkg::RST_BYTE;
    else if (!brg_run)
      brg_cnt <= baud_divisor;
    else if (brg_tick)
      brg_cnt <= baud_divisor;
    else
      brg_cnt <= brg_cnt - 8'h01;
  end

  // Prescaler used only at the low-speed setting.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_cnt <= '0;
    else if (!brg_run)
      pre_cnt <= '0;
    else if (brg_tick)
      pre_cnt <= pre_cnt + 2'h1;
  end

  // ---------------------------------------------------------------
  // Transmitter.
  // ---------------------------------------------------------------
  logic [10:0] tx_shift_reg; // Frame bits, next bit in bit 0.
  logic [3:0]  tx_steps;     // Bits left plus a final step.
  logic [3:0]  tx_phase;     // Sample phase within a bit.
  wire shift_reg_empty = tx_steps == '0;
  wire bit_tick = s_tick & (tx_phase == ast_pkg::PHASE_LAST);
  // A load defers to a buffer write in the same cycle.
  // reload after stop
  wire tx_load  = tx_on & shift_reg_empty & tx_buf_full &
                  ~sleep_mode & ~wr_tb;
  wire tx_nine  = tx_ctl[ast_pkg::TS_TX9];
  wire tx_b9    = tx_nine ? tx_ctl[ast_pkg::TS_TX_NINTH_BIT] : 1'b1;

  // Bit phase runs while the transmitter is on.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_phase <= '0;
    else if (!tx_on)
      tx_phase <= '0;
    else if (s_tick)
      tx_phase <= tx_phase + 4'h1;
  end

  // Shift register load, shift and abort.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_shift_reg <= '1;
      tx_steps     <= '0;
    end
    else if (!tx_on)
    begin
      tx_shift_reg <= '1;
      tx_steps     <= '0;
    end
    else if (tx_load)
    begin
      tx_shift_reg <= {1'b1, tx_b9, transmit_buffer, 1'b0};
      tx_steps     <= tx_nine ? ast_pkg::TX_STEPS_9
                              : ast_pkg::TX_STEPS_8;
    end
    else if (bit_tick && !shift_reg_empty)
    begin
      tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
      tx_steps     <= tx_steps - 4'h1;
    end
  end

  // Pin level and drive enable.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      transmit_pin_out <= 1'b1;
      transmit_pin_oe  <= 1'b0;
    end
    else
    begin
      transmit_pin_oe <= tx_on;
      if (!tx_on)
        transmit_pin_out <= 1'b1;
      else if (bit_tick && tx_steps > 4'h1)
        transmit_pin_out <= tx_shift_reg[0];
      else if (shift_reg_empty)
        transmit_pin_out <= 1'b1;
    end
  end

  // Buffer state and empty flag; a set wins over a clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_buf_full   <= 1'b0;
      tx_empty_flag <= 1'b0;
    end
    else
    begin
      if (wr_tb)
        tx_buf_full <= 1'b1;
      else if (tx_load)
        tx_buf_full <= 1'b0;
      if (tx_load || transmit_enable_set)
        tx_empty_flag <= 1'b1;
      else if (wr_tb)
        tx_empty_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Receiver.
  // ---------------------------------------------------------------
  ast_pkg::ast_rx_state_t rx_state;
  logic [3:0] rx_phase;     // Sample phase within a bit.
  logic [3:0] rx_idx;       // Data bit index.
  logic [8:0] rx_shift_reg; // Bits enter at the top.
  logic       samp_a;       // Seventh sample.
  logic       samp_b;       // Eighth sample.
  wire vote = (samp_a & samp_b) | (samp_a & receive_pin) |
              (samp_b & receive_pin);
  wire rx_go   = rx_on & s_tick;
  wire decide  = rx_go & (rx_phase == ast_pkg::SAMPLE_C) &
                 (rx_state != ast_pkg::RX_IDLE);
  wire rx_last = rx_idx == (rx9 ? ast_pkg::RX_LAST_9
                                : ast_pkg::RX_LAST_8);
  wire rx_done = decide & (rx_state == ast_pkg::RX_STOP);

  // Assembled word, aligned for eight or nine bits.
  ast_pkg::ast_rx_word_t rx_word;
  assign rx_word.data  = rx9 ? rx_shift_reg[7:0]
                             : rx_shift_reg[8:1];
  assign rx_word.ninth = rx9 & rx_shift_reg[8];
  assign rx_word.framing_error  = ~vote;

  // Frame sequencing; clearing the enable resets it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state     <= ast_pkg::RX_IDLE;
      rx_phase     <= '0;
      rx_idx       <= '0;
      rx_shift_reg <= '0;
      samp_a       <= 1'b1;
      samp_b       <= 1'b1;
    end
    else if (!rx_on)
    begin
      rx_state <= ast_pkg::RX_IDLE;
      rx_phase <= '0;
      rx_idx   <= '0;
    end
    else if (rx_go)
    begin
      rx_phase <= rx_phase + 4'h1;
      if (rx_phase == ast_pkg::SAMPLE_A)
        samp_a <= receive_pin;
      if (rx_phase == ast_pkg::SAMPLE_B)
        samp_b <= receive_pin;
      case (rx_state)
        // Falling line starts a frame.
        ast_pkg::RX_IDLE:
        begin
          rx_phase <= '0;
          if (!receive_pin)
            rx_state <= ast_pkg::RX_START;
        end
        // False start returns to idle.
        ast_pkg::RX_START:
        begin
          rx_idx <= '0;
          if (decide)
            rx_state <= vote ? ast_pkg::RX_IDLE
                             : ast_pkg::RX_DATA;
        end
        ast_pkg::RX_DATA:
        begin
          if (decide)
          begin
            rx_shift_reg <= {vote, rx_shift_reg[8:1]};
            rx_idx       <= rx_idx + 4'h1;
            if (rx_last)
              rx_state <= ast_pkg::RX_STOP;
          end
        end
        ast_pkg::RX_STOP:
        begin
          if (decide)
            rx_state <= ast_pkg::RX_IDLE;
        end
        default:
          rx_state <= ast_pkg::RX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receive buffer.
  // ---------------------------------------------------------------
  ast_pkg::ast_rx_word_t fifo_mem [RX_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   fifo_cnt;
  wire fifo_full  = fifo_cnt == FIFO_FULL;
  wire fifo_empty = fifo_cnt == '0;
  wire addr_drop  = rx9 & rx_ctl[ast_pkg::RS_ADDRESS_DETECT_ENABLE] & ~rx_word.ninth;
  wire rx_ok      = rx_done & ~overrun_error & ~addr_drop;
  wire rx_ovr     = rx_ok & fifo_full;
  wire push       = rx_ok & ~fifo_full;
  wire do_pop     = pop & ~fifo_empty;
  ast_pkg::ast_rx_word_t head;
  assign head = fifo_mem[rd_ptr];

  always_ff @(posedge pclk)
  begin
    if (push)
      fifo_mem[wr_ptr] <= rx_word;
  end

  // Pointers and fill count.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      fifo_cnt <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      if (push && !do_pop)
        fifo_cnt <= fifo_cnt + 1'b1;
      else if (do_pop && !push)
        fifo_cnt <= fifo_cnt - 1'b1;
    end
  end

  // Overrun sticks until the receive enable is cleared.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_error <= 1'b0;
    else if (rx_ovr)
      overrun_error <= 1'b1;
    else if (!rx_ctl[ast_pkg::RS_CONTINUOUS_RX_ENABLE])
      overrun_error <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Register writes.
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_ctl          <= ast_pkg::RST_BYTE;
      tx_ctl          <= ast_pkg::RST_BYTE;
      transmit_buffer <= ast_pkg::RST_BYTE;
      enables         <= ast_pkg::RST_BYTE;
      baud_divisor    <= ast_pkg::RST_BYTE;
    end
    else if (wr && hit)
    begin
      if (s_rs)
        rx_ctl <= wbyte & ast_pkg::RS_RW_MASK;
      if (s_ts)
        tx_ctl <= wbyte & ast_pkg::TS_RW_MASK;
      if (s_tb)
        transmit_buffer <= wbyte;
      if (s_en)
        enables <= wbyte;
      if (s_bd)
        baud_divisor <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // Read data and answer.
  // ---------------------------------------------------------------
  wire [7:0] fl_rd = 8'(((fifo_empty ? 0 : 1) << ast_pkg::FL_RX_READY)
                   | (int'(tx_empty_flag) << ast_pkg::FL_TX_EMPTY));
  wire [7:0] rs_rd = rx_ctl
                   | 8'(int'(~fifo_empty & head.framing_error) << ast_pkg::RS_FRAMING_ERROR)
                   | 8'(int'(overrun_error) << ast_pkg::RS_OVERRUN_ERROR)
                   | 8'(int'(~fifo_empty & head.ninth) << ast_pkg::RS_RX_NINTH_BIT);
  wire [7:0] ts_rd = tx_ctl
                   | 8'(int'(shift_reg_empty) << ast_pkg::TS_SHIFT_REG_EMPTY);
  wire [7:0] rb_rd = fifo_empty ? ast_pkg::RST_BYTE : head.data;
  wire [7:0] rd_mux = s_fl ? fl_rd : s_rs ? rs_rd :
                      s_tb ? transmit_buffer : s_rb ? rb_rd :
                      s_en ? enables : s_ts ? ts_rd : baud_divisor;

  // One wait state: data is captured as pready rises.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc && !pready)
        prdata <= (hit && !pwrite) ? {24'h00_0000, rd_mux} : '0;
    end
  end

endmodule

// ### verification/ast_serial_port_assertions.sv
// Port checker for the async serial port.
// Assumes it is bound onto ast_serial_port.
`timescale 1ns/1ps
module ast_serial_port_assertions
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset.
  input wire logic              pclk,
  input wire logic              presetn,
  // Bus.
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Power and serial pin.
  input wire logic              sleep_mode,
  input wire logic              transmit_pin_out,
  input wire logic              transmit_pin_oe
);
  // A write that completes at this edge.
  wire wr_done = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wait; psel && penable && !$past(penable) |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error response bad");
  property p_hi; pready |-> prdata[31:8] == 24'h00_0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_rel; !transmit_pin_oe |-> transmit_pin_out; endproperty
  a_rel: assert property (p_rel) else $error("released pin low");
  property p_idle; $rose(transmit_pin_oe) |-> transmit_pin_out; endproperty
  a_idle: assert property (p_idle) else $error("enable not idle");
  property p_abort;
    $fell(transmit_pin_oe) |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_abort: assert property (p_abort) else $error("pin drop uncaused");
  property p_sleep;
    sleep_mode && $past(sleep_mode) && !psel |-> $stable(transmit_pin_out);
  endproperty
  a_sleep: assert property (p_sleep) else $error("pin moved asleep");
endmodule

bind ast_serial_port ast_serial_port_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_mode(sleep_mode),
  .transmit_pin_out(transmit_pin_out), .transmit_pin_oe(transmit_pin_oe));

// ### verification/ast_peer_model.sv
// Remote serial peer: drives frames in and captures frames out.
// Assumes a bit time of BIT pclk cycles and a pulled-up line.
`timescale 1ns/1ps
module ast_peer_model
#(
  parameter int BIT = 16
)
(
  // Clock.
  input  wire logic pclk,
  // Serial lines.
  input  wire logic line,
  input  wire logic nine,
  output logic      rx_pin
);
  logic [8:0] got;      // Last captured word.
  logic       stop_bit; // Stop level of the last captured frame.
  int         rx_cnt;   // Frames captured.
  int         k;        // Capture bit index.
  int         bit_len;  // Bit time in pclk cycles; the bench may change it.
  initial
  begin
    rx_pin   = 1'b1;
    rx_cnt   = 0;
    got      = 9'h000;
    stop_bit = 1'b0;
    bit_len  = BIT;
  end
  // start, data LSB first, stop; a bad stop is shortened.
  task automatic send(input logic [8:0] w, input logic nb, input logic stp);
    int i;
    rx_pin <= 1'b0;
    repeat (bit_len) @(posedge pclk);
    for (i = 0; i < (nb ? 9 : 8); i++)
    begin
      rx_pin <= w[i];
      repeat (bit_len) @(posedge pclk);
    end
    rx_pin <= stp;
    repeat (stp ? bit_len : 10) @(posedge pclk);
    rx_pin <= 1'b1;
    repeat (bit_len) @(posedge pclk);
  endtask
  // mid-bit capture of frames sent by the port, stop included.
  always
  begin
    @(negedge line);
    repeat (bit_len / 2) @(posedge pclk);
    for (k = 0; k < 9; k++)
    begin
      if (k < 8 || nine)
      begin
        repeat (bit_len) @(posedge pclk);
      end
      got[k] = (k < 8 || nine) ? line : 1'b0;
    end
    repeat (bit_len) @(posedge pclk);
    stop_bit = line;
    rx_cnt++;
  end
endmodule

// ### verification/tb.sv
// Self-checking bench for the async serial port.
// Assumes the peer model and baud divisor zero at high speed.
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] FL = ast_pkg::IDX_FLAGS;
  localparam logic [7:0] RS = ast_pkg::IDX_RX_STAT;
  localparam logic [7:0] TB = ast_pkg::IDX_TX_BUF;
  localparam logic [7:0] RB = ast_pkg::IDX_RX_BUF;
  localparam logic [7:0] TS = ast_pkg::IDX_TX_STAT;
  // Bus, pins and bookkeeping.
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        sleep_mode = 1'b0;
  logic        nine = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_pin;
  logic        tx_out;
  logic        tx_oe;
  logic [31:0] rd;
  logic        err;
  int          fails = 0;
  int          cmp_count = 0;
  int          n0;
  wire         tx_line = tx_oe ? tx_out : 1'b1; // Pulled-up line.
  always #12.5 pclk = ~pclk;
  ast_serial_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .receive_pin(rx_pin),
    .transmit_pin_out(tx_out), .transmit_pin_oe(tx_oe));
  ast_peer_model u_peer (.pclk(pclk), .line(tx_line), .nine(nine),
    .rx_pin(rx_pin));
  // Prints the verdict and stops.
  task automatic end_sim();
    $display("%0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Compares one value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16 && pready !== 1'b1; i++)
      @(posedge pclk);
    if (i == 16)
    begin
      fails++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // Waits a bounded time for n captured frames, then checks the word.
  task automatic rxw(input int n, input logic [31:0] exp);
    int i;
    for (i = 0; i < 3000 && u_peer.rx_cnt < n; i++)
      @(posedge pclk);
    if (i == 3000)
    begin
      fails++;
      end_sim();
    end
    chk({23'h00_0000, u_peer.got}, exp);
    chk({31'h0, u_peer.stop_bit}, 32'h0000_0001);
  endtask
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(TS, 32'h0000_0002);
    rdc(FL, 32'h0000_0000);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, ast_pkg::IDX_BAUD, 32'h0000_0000);
    apb(1'b1, RS, 32'h0000_0090);
    apb(1'b1, TS, 32'h0000_0024);
    rdc(FL, 32'h0000_0010);
    apb(1'b1, FL, 32'h0000_0000);
    rdc(FL, 32'h0000_0010);
    $display("test setup done");
    n0 = u_peer.rx_cnt;
    apb(1'b1, TB, 32'h0000_005a);
    apb(1'b1, TB, 32'h0000_00c3);
    rdc(FL, 32'h0000_0000);
    rdc(TS, 32'h0000_0024);
    rxw(n0 + 1, 32'h0000_005a);
    rxw(n0 + 2, 32'h0000_00c3);
    repeat (20) @(posedge pclk);
    rdc(TS, 32'h0000_0026);
    // ninth bit written before the data byte.
    apb(1'b1, TS, 32'h0000_0065);
    nine <= 1'b1;
    apb(1'b1, TB, 32'h0000_0081);
    rxw(n0 + 3, 32'h0000_0181);
    nine <= 1'b0;
    apb(1'b1, TS, 32'h0000_0024);
    apb(1'b1, TB, 32'h0000_0055);
    repeat (40) @(posedge pclk);
    apb(1'b1, TS, 32'h0000_0004);
    rdc(TS, 32'h0000_0006);
    chk({31'h0, tx_oe}, 32'h0000_0000);
    repeat (200) @(posedge pclk);
    apb(1'b1, TS, 32'h0000_0024);
    n0 = u_peer.rx_cnt;
    apb(1'b1, TB, 32'h0000_0096);
    sleep_mode <= 1'b1;
    repeat (64) @(posedge pclk);
    sleep_mode <= 1'b0;
    rxw(n0 + 1, 32'h0000_0096);
    $display("test transmit done");
    u_peer.send(9'h011, 1'b0, 1'b1);
    u_peer.send(9'h022, 1'b0, 1'b1);
    u_peer.send(9'h033, 1'b0, 1'b1);
    apb(1'b0, FL, 32'h0000_0000);
    chk({31'h0, rd[5]}, 32'h0000_0001);
    rdc(RS, 32'h0000_0092);
    rdc(RB, 32'h0000_0011);
    rdc(RB, 32'h0000_0022);
    apb(1'b0, FL, 32'h0000_0000);
    chk({31'h0, rd[5]}, 32'h0000_0000);
    apb(1'b1, RS, 32'h0000_0080);
    u_peer.send(9'h044, 1'b0, 1'b1);
    apb(1'b1, RS, 32'h0000_0090);
    rdc(RS, 32'h0000_0090);
    apb(1'b0, FL, 32'h0000_0000);
    chk({31'h0, rd[5]}, 32'h0000_0000);
    apb(1'b1, RS, 32'h0000_00d0);
    u_peer.send(9'h1a5, 1'b1, 1'b1);
    u_peer.send(9'h03c, 1'b1, 1'b0);
    rdc(RS, 32'h0000_00d1);
    rdc(RB, 32'h0000_00a5);
    rdc(RS, 32'h0000_00d4);
    rdc(RB, 32'h0000_003c);
    apb(1'b1, RS, 32'h0000_00d8);
    u_peer.send(9'h077, 1'b1, 1'b1);
    u_peer.send(9'h1ee, 1'b1, 1'b1);
    rdc(RB, 32'h0000_00ee);
    apb(1'b0, FL, 32'h0000_0000);
    chk({31'h0, rd[5]}, 32'h0000_0000);
    $display("test receive done");
    // Low-speed setting: four generator ticks per sample tick.
    apb(1'b1, TS, 32'h0000_0020);
    apb(1'b1, RS, 32'h0000_0090);
    u_peer.bit_len = 64;
    n0 = u_peer.rx_cnt;
    apb(1'b1, TB, 32'h0000_00a7);
    rxw(n0 + 1, 32'h0000_00a7);
    u_peer.send(9'h069, 1'b0, 1'b1);
    rdc(RB, 32'h0000_0069);
    // Sync select stops the port and releases the pin.
    apb(1'b1, TS, 32'h0000_0030);
    rdc(TS, 32'h0000_0032);
    chk({31'h0, tx_oe}, 32'h0000_0000);
    $display("test low speed done");
    end_sim();
  end
  // Cuts a hung run short.
  initial
  begin
    #1000000;
    fails++;
    end_sim();
  end
endmodule
